// ---- pkg/ccpm_pkg.sv ----
// Overview of operation
// - bit clock rise samples master clock level: 1 rising, 0 falling
// - internal master clock phase chosen so bit clock rises while it is high
// - bit period split into master clock slots; data and hold slots differ
// - phase relationship found only at initialisation, never in operation
// - drift sums over all time; beyond plus or minus ten periods, self reset
// - wrongly resolved phase sample cuts tolerance to nine and a half periods
// - reset enters at once; leaves after release and two later bit clock rises
package ccpm_pkg;
	// drift is counted in half master clock periods, one per master clock edge
	localparam int unsigned FRAME_MCLKS = 256;
	localparam int unsigned DRIFT_LIMIT_HALF = 20;
	localparam int unsigned DRIFT_LIMIT_REDUCED_HALF = 19;
	localparam int unsigned DRIFT_W = 16;
	localparam int unsigned SLOTS = 4;
	localparam int unsigned DATA_SLOT = 0;
	localparam int unsigned HOLD_SLOT = 2;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// pin indices inside the synchroniser vector
	localparam int unsigned PIN_MCLK = 0;
	localparam int unsigned PIN_SCLK = 1;
	localparam int unsigned PIN_LRCLK = 2;
	localparam int unsigned PIN_DATA = 3;
	localparam int unsigned PIN_CNT = 4;
	localparam logic [3:0] SYNC_RESET = 4'h0;
	localparam logic PHASE_RESET = 1'b0;
	typedef enum logic [2:0] {
		CCPM_ST_RESET = 3'b001,
		CCPM_ST_SAMPLE = 3'b010,
		CCPM_ST_RUN = 3'b100
	} ccpm_state_e;
endpackage

// ---- rtl/ccpm_slot_sched.sv ----
`timescale 1ns/10ps
module ccpm_slot_sched #(
	parameter int unsigned SLOTS = ccpm_pkg::SLOTS,
	parameter int unsigned DATA_SLOT = ccpm_pkg::DATA_SLOT,
	parameter int unsigned HOLD_SLOT = ccpm_pkg::HOLD_SLOT
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic run_i,
	input wire logic sclk_rise_i,
	input wire logic mclk_rise_i,
	input wire logic data_i,
	output logic data_strobe_o,
	output logic hold_update_o,
	output logic data_bit_o
);
	localparam int unsigned SW = $clog2(SLOTS + 1);
	localparam logic [SW-1:0] LAST = SW'(SLOTS - 1);
	localparam logic [SW-1:0] DSLOT = SW'(DATA_SLOT);
	localparam logic [SW-1:0] HSLOT = SW'(HOLD_SLOT);

	// slots must exist and never coincide
	if (SLOTS < 2 || DATA_SLOT >= SLOTS || HOLD_SLOT >= SLOTS ||
		DATA_SLOT == HOLD_SLOT) begin : g_bad
		$error("slot schedule parameters out of range");
	end

	logic [SW-1:0] slot_reg, slot_next;
	logic dstb_reg, dstb_next, hold_reg, hold_next, bit_reg, bit_next;

	// slot count restarts at each bit clock rise, steps on internal mclk rise
	always_comb begin
		slot_next = slot_reg;
		dstb_next = 1'b0;
		hold_next = 1'b0;
		bit_next = bit_reg;
		if (sclk_rise_i) begin
			slot_next = '0;
		end else if (mclk_rise_i && run_i) begin
			if (slot_reg == DSLOT) begin
				dstb_next = 1'b1;
				bit_next = data_i;
			end
			if (slot_reg == HSLOT) begin
				hold_next = 1'b1;
			end
			if (slot_reg != LAST) begin
				slot_next = slot_reg + SW'(1);
			end
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			slot_reg <= '0;
			dstb_reg <= 1'b0;
			hold_reg <= 1'b0;
			bit_reg <= 1'b0;
		end else begin
			slot_reg <= slot_next;
			dstb_reg <= dstb_next;
			hold_reg <= hold_next;
			bit_reg <= bit_next;
		end
	end

	assign data_strobe_o = dstb_reg;
	assign hold_update_o = hold_reg;
	assign data_bit_o = bit_reg;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	a_slots_apart: assert property (
		(data_strobe_o |-> (!hold_update_o) [*2]) and
		(hold_update_o |=> !data_strobe_o))
		else $error("data and hold events share a slot");
	a_data_capture: assert property (
		data_strobe_o |-> data_bit_o == $past(data_i) &&
		$past(slot_reg) == DSLOT)
		else $error("data bit not taken in its slot");
endmodule // ccpm_slot_sched

// ---- rtl/ccpm_top.sv ----
`timescale 1ns/10ps
module ccpm_top #(
	parameter int unsigned FRAME_MCLKS = ccpm_pkg::FRAME_MCLKS,
	parameter int unsigned DRIFT_W = ccpm_pkg::DRIFT_W
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic master_clock_i,
	input wire logic bit_clock_i,
	input wire logic frame_clock_i,
	input wire logic serial_audio_input_i,
	output logic device_in_reset_o,
	output logic phase_sample_o,
	output logic internal_mclk_o,
	output logic tolerance_reduced_o,
	output logic drift_reset_o,
	output logic [DRIFT_W-1:0] drift_value_o,
	output logic data_strobe_o,
	output logic hold_update_o,
	output logic data_bit_o
);
	localparam int unsigned CW = DRIFT_W - 1;
	localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};
	localparam logic signed [DRIFT_W-1:0] EXP_HALF =
		DRIFT_W'(2 * FRAME_MCLKS);
	localparam logic [DRIFT_W-1:0] LIM_FULL =
		DRIFT_W'(ccpm_pkg::DRIFT_LIMIT_HALF);
	localparam logic [DRIFT_W-1:0] LIM_RED =
		DRIFT_W'(ccpm_pkg::DRIFT_LIMIT_REDUCED_HALF);
	localparam int unsigned M = ccpm_pkg::PIN_MCLK;
	localparam int unsigned S = ccpm_pkg::PIN_SCLK;
	localparam int unsigned L = ccpm_pkg::PIN_LRCLK;
	localparam int unsigned D = ccpm_pkg::PIN_DATA;

	// edge counter must hold a whole frame of master clock edges
	if (DRIFT_W < 8 || FRAME_MCLKS < 2 ||
		2 * FRAME_MCLKS >= (1 << (DRIFT_W - 2))) begin : g_bad
		$error("drift width too small for the frame length");
	end

	function automatic logic [DRIFT_W-1:0] magnitude(
		input logic signed [DRIFT_W-1:0] v);
		magnitude = v[DRIFT_W-1] ? DRIFT_W'(-v) : DRIFT_W'(v);
	endfunction

	// all pins are asynchronous to clock_i: two flops before any use
	logic [ccpm_pkg::PIN_CNT-1:0] meta_reg, meta_next;
	logic [ccpm_pkg::PIN_CNT-1:0] sync_reg, sync_next;
	logic [ccpm_pkg::PIN_CNT-1:0] prev_reg, prev_next;
	// edges count only once all three stages hold real pin data, so a pin that
	// is already high at reset release never looks like a rising edge
	logic [2:0] fill_reg, fill_next;
	logic primed;

	always_comb begin
		meta_next = {serial_audio_input_i, frame_clock_i, bit_clock_i,
			master_clock_i};
		sync_next = meta_reg;
		prev_next = sync_reg;
		fill_next = {fill_reg[1:0], 1'b1};
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_reg <= ccpm_pkg::SYNC_RESET;
			sync_reg <= ccpm_pkg::SYNC_RESET;
			prev_reg <= ccpm_pkg::SYNC_RESET;
			fill_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
			fill_reg <= fill_next;
		end
	end

	// sampling resolution is one clock_i period; the far end must keep
	// master clock edges well away from the bit clock rise
	logic sclk_rise, lr_rise, mclk_edge, int_mclk, int_mclk_prev;
	logic int_mclk_rise;
	ccpm_pkg::ccpm_state_e state_reg, state_next;
	logic phase_reg, phase_next;

	assign primed = fill_reg[2];
	assign sclk_rise = primed & sync_reg[S] & ~prev_reg[S];
	assign lr_rise = primed & sync_reg[L] & ~prev_reg[L];
	assign mclk_edge = primed & (sync_reg[M] ^ prev_reg[M]);
	// sampled 1 keeps mclk as is, sampled 0 takes its inverse
	assign int_mclk = sync_reg[M] ^ ~phase_reg;
	assign int_mclk_prev = prev_reg[M] ^ ~phase_reg;
	assign int_mclk_rise = primed & int_mclk & ~int_mclk_prev;

	logic signed [DRIFT_W-1:0] drift_reg, drift_next;
	logic [CW-1:0] ecnt_reg, ecnt_next;
	logic frame_ok_reg, frame_ok_next;
	logic bad_reg, bad_next;
	logic dreset_reg, dreset_next;
	logic imclk_reg, imclk_next;
	logic [DRIFT_W-1:0] drift_mag, limit;
	logic over;

	assign drift_mag = magnitude(drift_reg);
	assign limit = bad_reg ? LIM_RED : LIM_FULL;
	assign over = drift_mag > limit;

	// phase detection, drift accumulation and self reset
	always_comb begin
		state_next = state_reg;
		phase_next = phase_reg;
		drift_next = drift_reg;
		ecnt_next = ecnt_reg;
		frame_ok_next = frame_ok_reg;
		bad_next = bad_reg;
		dreset_next = 1'b0;
		imclk_next = (state_reg == ccpm_pkg::CCPM_ST_RUN) & int_mclk;
		case (state_reg)
			ccpm_pkg::CCPM_ST_RESET: begin
				if (sclk_rise) begin
					state_next = ccpm_pkg::CCPM_ST_SAMPLE;
				end
			end
			ccpm_pkg::CCPM_ST_SAMPLE: begin
				if (sclk_rise) begin
					phase_next = sync_reg[M];
					state_next = ccpm_pkg::CCPM_ST_RUN;
					drift_next = '0;
					ecnt_next = '0;
					frame_ok_next = 1'b0;
					bad_next = 1'b0;
				end
			end
			ccpm_pkg::CCPM_ST_RUN: begin
				// phase stays fixed here; a low internal clock at a bit
				// clock rise only reveals a bad first sample
				if (sclk_rise && !int_mclk) begin
					bad_next = 1'b1;
				end
				if (mclk_edge && ecnt_reg != CNT_MAX) begin
					ecnt_next = ecnt_reg + CW'(1);
				end
				// one common base clock makes the per-frame count exact
				if (lr_rise) begin
					ecnt_next = CW'(mclk_edge);
					frame_ok_next = 1'b1;
					if (frame_ok_reg) begin
						drift_next = drift_reg +
							$signed({1'b0, ecnt_reg}) - EXP_HALF;
					end
				end
				if (over) begin
					dreset_next = 1'b1;
					state_next = ccpm_pkg::CCPM_ST_SAMPLE;
					drift_next = '0;
					ecnt_next = '0;
					frame_ok_next = 1'b0;
				end
			end
			default: begin
				state_next = ccpm_pkg::CCPM_ST_RESET;
			end
		endcase
	end

	// external reset acts at once, without waiting for any clock
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= ccpm_pkg::CCPM_ST_RESET;
			phase_reg <= ccpm_pkg::PHASE_RESET;
			drift_reg <= '0;
			ecnt_reg <= '0;
			frame_ok_reg <= 1'b0;
			bad_reg <= 1'b0;
			dreset_reg <= 1'b0;
			imclk_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			drift_reg <= drift_next;
			ecnt_reg <= ecnt_next;
			frame_ok_reg <= frame_ok_next;
			bad_reg <= bad_next;
			dreset_reg <= dreset_next;
			imclk_reg <= imclk_next;
		end
	end

	// data and hold activities placed in separate master clock slots
	ccpm_slot_sched #(
		.SLOTS(ccpm_pkg::SLOTS),
		.DATA_SLOT(ccpm_pkg::DATA_SLOT),
		.HOLD_SLOT(ccpm_pkg::HOLD_SLOT)
	) u_slots (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.run_i(state_reg == ccpm_pkg::CCPM_ST_RUN),
		.sclk_rise_i(sclk_rise),
		.mclk_rise_i(int_mclk_rise),
		.data_i(sync_reg[D]),
		.data_strobe_o(data_strobe_o),
		.hold_update_o(hold_update_o),
		.data_bit_o(data_bit_o)
	);

	assign device_in_reset_o = (state_reg != ccpm_pkg::CCPM_ST_RUN);
	assign phase_sample_o = phase_reg;
	assign internal_mclk_o = imclk_reg;
	assign tolerance_reduced_o = bad_reg;
	assign drift_reset_o = dreset_reg;
	assign drift_value_o = drift_reg;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	a_phase_capture: assert property (
		(state_reg == ccpm_pkg::CCPM_ST_SAMPLE && sclk_rise) |=>
		phase_reg == $past(sync_reg[M]) &&
		state_reg == ccpm_pkg::CCPM_ST_RUN)
		else $error("phase not taken from master clock level");
	a_int_high: assert property (
		(state_reg == ccpm_pkg::CCPM_ST_RUN && sclk_rise) |=>
		internal_mclk_o || tolerance_reduced_o)
		else $error("internal clock low at bit clock rise");
	a_phase_fixed: assert property (
		(state_reg == ccpm_pkg::CCPM_ST_RUN && !over) |=>
		$stable(phase_reg))
		else $error("phase changed during operation");
	a_full_limit: assert property (
		(state_reg == ccpm_pkg::CCPM_ST_RUN && !bad_reg &&
		drift_mag == LIM_FULL) |=> !drift_reset_o)
		else $error("reset at exactly ten periods of drift");
	a_exceed_reset: assert property (
		(state_reg == ccpm_pkg::CCPM_ST_RUN &&
		drift_mag > LIM_FULL) |=> drift_reset_o)
		else $error("no reset beyond ten periods of drift");
	a_reduced_limit: assert property (
		(state_reg == ccpm_pkg::CCPM_ST_RUN && bad_reg &&
		drift_mag == LIM_FULL) |=> drift_reset_o)
		else $error("reduced tolerance not applied");
	a_reset_hold: assert property (
		(state_reg == ccpm_pkg::CCPM_ST_RESET && !sclk_rise) |=>
		state_reg == ccpm_pkg::CCPM_ST_RESET)
		else $error("left reset without bit clock rise");
	a_resample: assert property (
		drift_reset_o |-> drift_reg == '0 &&
		state_reg == ccpm_pkg::CCPM_ST_SAMPLE && device_in_reset_o)
		else $error("drift reset did not clear and resample");
endmodule // ccpm_top

// ---- testbench/ccpm_port_model.sv ----
`timescale 1ns/10ps
module ccpm_port_model (
	input wire logic enable_i,
	input wire logic phase_i,
	input wire logic [3:0] extra_i,
	input wire logic [15:0] pattern_i,
	output logic mclk_o,
	output logic sclk_o,
	output logic lrclk_o,
	output logic data_o
);
	int t = 0;
	int off;
	int bp = 0;
	int lp = 0;
	int ll = 64;
	initial begin
		mclk_o = 1'b1;
		sclk_o = 1'b0;
		lrclk_o = 1'b0;
		data_o = 1'b0;
	end
	// one 20 ns base tick makes every clock, so no slip between them
	always begin
		#20;
		t = t + 1;
		off = phase_i ? 1 : 3;
		mclk_o = (t % 4) < 2;
		if (!enable_i) begin
			data_o = ~data_o; // idle data keeps moving
		end else if ((t - off) % 16 == 0) begin
			sclk_o = 1'b1;
		end else if ((t - off) % 16 == 8) begin
			sclk_o = 1'b0;
			bp = bp + 1;
			data_o = pattern_i[bp % 16];
		end
		// frame length taken at frame start; extra periods make drift
		if (enable_i) begin
			lp = lp + 1;
			if (lp >= ll) begin
				lp = 0;
				ll = (16 + extra_i) * 4;
			end
			lrclk_o = lp < ll / 2;
		end
	end
endmodule // ccpm_port_model

// ---- testbench/codec_clock_phase_monitor_tb.sv ----
`timescale 1ns/10ps
module codec_clock_phase_monitor_tb;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic en = 1'b0;
	logic ph = 1'b1;
	logic [3:0] extra = 4'h0;
	logic [15:0] pat = 16'h0;
	logic mclk, sclk, lrclk, sd;
	logic inr, psm, imc, tol, drst, stb, hld, dbit;
	logic [15:0] drift;
	logic [15:0] last_drift = 16'h0;
	logic [15:0] peak = 16'h0;
	int bad_count = 0;
	int n_checks = 0;
	int holds = 0;
	int strobes = 0;
	int pulses = 0;
	always #5 clock_i = ~clock_i;
	ccpm_port_model port (.enable_i(en), .phase_i(ph), .extra_i(extra),
		.pattern_i(pat), .mclk_o(mclk), .sclk_o(sclk), .lrclk_o(lrclk),
		.data_o(sd));
	ccpm_top #(.FRAME_MCLKS(16)) dut (.clock_i(clock_i),
		.reset_n_i(reset_n_i), .master_clock_i(mclk), .bit_clock_i(sclk),
		.frame_clock_i(lrclk), .serial_audio_input_i(sd),
		.device_in_reset_o(inr), .phase_sample_o(psm),
		.internal_mclk_o(imc), .tolerance_reduced_o(tol),
		.drift_reset_o(drst), .drift_value_o(drift),
		.data_strobe_o(stb), .hold_update_o(hld), .data_bit_o(dbit));
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// bounded waits; a reset level or pulse count that never comes fails
	task automatic wait_inr(input logic want);
		int n;
		n = 0;
		while (inr !== want && n < 5000) begin
			@(negedge clock_i);
			n++;
		end
		check("device_in_reset", inr, want);
	endtask
	task automatic wait_pulses(input int want);
		int n;
		n = 0;
		while (pulses < want && n < 20000) begin
			@(negedge clock_i);
			n++;
		end
		check("drift_pulses", 16'(pulses), 16'(want));
	endtask
	// model: drift grows by a fixed step per frame until past the limit
	function automatic logic [15:0] peak_of(input int step, input int lim);
		int d;
		d = 0;
		while (d <= lim) d += step;
		return 16'(d);
	endfunction
	// result monitor at settled points: slots, data bits and drift resets
	always @(negedge clock_i) begin
		if (inr === 1'b1) begin
			strobes = 0;
			holds = 0;
		end
		if (stb === 1'b1) begin
			check("data_bit", dbit, sd);
			check("internal_mclk", imc, 1'b1);
			check("slots_apart", hld, 1'b0);
			if (strobes > 0) check("holds_per_bit", 16'(holds), 16'h1);
			strobes++;
			holds = 0;
		end
		if (hld === 1'b1) holds++;
		if (drst === 1'b1) begin
			pulses++;
			extra = 4'h0;
			check("drift_peak", last_drift, peak);
			check("drift_cleared", drift, 16'h0);
			check("reset_on_drift", inr, 1'b1);
			@(negedge clock_i);
			check("pulse_one_cycle", drst, 1'b0);
		end else if (drift !== 16'h0) begin
			last_drift = drift;
		end
	end
	initial begin
		#200us;
		bad_count++;
		$display("watchdog expired");
		complete_run();
	end
	// main sequence
	initial begin
		void'($urandom(81));
		pat = 16'($urandom());
		repeat (10) @(negedge clock_i);
		check("in_reset_held", inr, 1'b1);
		check("no_pulse_in_reset", drst, 1'b0);
		reset_n_i = 1'b1;
		repeat (50) @(negedge clock_i);
		check("wait_bit_clock", inr, 1'b1);
		$display("test reset done");
		en = 1'b1;
		wait_inr(1'b0);
		check("phase_rising", psm, 1'b1);
		repeat (400) @(negedge clock_i);
		pat = 16'($urandom());
		repeat (400) @(negedge clock_i);
		check("phase_kept", tol, 1'b0);
		check("strobes_run", 16'(strobes > 8), 16'h1);
		$display("test phase rising done");
		peak = peak_of(10, ccpm_pkg::DRIFT_LIMIT_HALF);
		extra = 4'h5;
		wait_pulses(1);
		wait_inr(1'b0);
		check("resampled", psm, 1'b1);
		$display("test drift limit done");
		reset_n_i = 1'b0;
		en = 1'b0;
		ph = 1'b0;
		repeat (2) @(negedge clock_i);
		check("async_reset", inr, 1'b1);
		reset_n_i = 1'b1;
		en = 1'b1;
		wait_inr(1'b0);
		check("phase_falling", psm, 1'b0);
		repeat (200) @(negedge clock_i);
		ph = 1'b1;
		repeat (200) @(negedge clock_i);
		check("wrong_phase_seen", tol, 1'b1);
		check("no_reevaluate", psm, 1'b0);
		peak = peak_of(10, ccpm_pkg::DRIFT_LIMIT_REDUCED_HALF);
		extra = 4'h5;
		wait_pulses(2);
		wait_inr(1'b0);
		check("resample_phase", psm, 1'b1);
		check("tolerance_back", tol, 1'b0);
		$display("test reduced tolerance done");
		complete_run();
	end
endmodule // codec_clock_phase_monitor_tb
